//--- rtl/fpc_flash_program_control.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - after reset user array is code-read only; data writes leave it alone
// - map bit one sends flash-window data accesses to latches, zero restores RAM
// - address bits 6:0 pick byte, bits 14:7 pick target page
// - latch writes accepted for data addresses 0000h to 0FFFh when mapped
// - space select steers code reads: user, extra row, security byte, reserved
// - launch only after key 5 then key A written to launch field
// - any other instruction between the two key writes aborts the launch
// - second key programs selected space; reserved or lone first write does nothing
// - busy set by hardware while programming, cleared by hardware, never by software
// - launch erases only loaded locations, then programs them
// - one to 128 loaded bytes programmed; unloaded bytes untouched
// - page of the latest latch write is the target page
// - level 2 blocks programmer writes; level 3 blocks programmer writes and reads
// - lock bits in security byte change only through parallel programming
// - control register resets to all zeros
// - latch buffer is one full page feeding user, extra row and security byte
module fpc_flash_program_control
  import fpc_pkg::*;
#(
  parameter int ERASE_CYC = FPC_ERASE_CYC,
  parameter int PROG_CYC  = FPC_PROG_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdata,
  // core instruction boundary, one pulse per executed instruction
  input  wire logic        instrDone,
  // core data-space write
  input  wire logic        dataWr,
  input  wire logic [15:0] dataAddr,
  input  wire logic [7:0]  dataWdata,
  output logic             dataToLatch,
  // core code-space read
  input  wire logic        codeRd,
  input  wire logic [15:0] codeAddr,
  output logic      [7:0]  codeRdata,
  // external parallel programmer
  input  wire logic        pgmWr,
  input  wire logic        pgmRd,
  input  wire logic [15:0] pgmAddr,
  input  wire logic [7:0]  pgmWdata,
  output logic      [7:0]  pgmRdata,
  output logic             pgmBlocked,
  // status
  output logic             programInProgress
);

  localparam int PAGES  = 1 << FPC_PAGE_BITS;
  localparam int UBYTES = PAGES * FPC_PAGE_BYTES;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0]                launchKey;
    logic                      latchMapEnable;
    logic [1:0]                spaceSelect;
    logic                      armed;
    logic                      armedSeen;
    fpc_state_t                state;
    fpc_sel_t                  target;
    logic [FPC_PAGE_BITS-1:0]  page;
    logic [FPC_PAGE_BYTES-1:0] loaded;
    logic [15:0]               timer;
    logic [7:0]                regRdata;
    logic [7:0]                codeRdata;
    logic [7:0]                pgmRdata;
  } fpc_regs_t;

  fpc_regs_t st_r;
  fpc_regs_t st_nxt;

  // memories kept apart from the struct to stay inferable
  logic [7:0] latchMem [FPC_PAGE_BYTES];
  logic [7:0] userMem  [UBYTES];
  logic [7:0] xrowMem  [FPC_PAGE_BYTES];
  logic [7:0] securByte;

  logic       latchWr;
  logic       keyWr;
  logic       launch;
  logic [1:0] lockBits;

  assign lockBits = {securByte[1], securByte[0]};

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // latch window while mapped: low 4 KB, plus FF80h and up when extra row is selected
  always_comb begin
    latchWr = 1'b0;
    if (dataWr && st_r.latchMapEnable) begin
      if (dataAddr <= FPC_LATCH_MAX) begin
        latchWr = 1'b1;
      end else if (st_r.spaceSelect == FPC_SEL_EXTRA_ROW && dataAddr >= FPC_EXTRA_ROW_BASE) begin
        latchWr = 1'b1;
      end
    end
  end
  // an unmapped data write falls through to normal RAM, array untouched
  assign dataToLatch = latchWr;

  assign keyWr  = regWr && (regAddr == FPC_FLASH_CONTROL_ADDR);
  // second key only counts if the previous instruction was the first key
  assign launch = keyWr && st_r.armed && !st_r.armedSeen
                  && (regWdata[FPC_KEY_HI:FPC_KEY_LO] == FPC_KEY_SECOND)
                  && (regWdata[FPC_SEL_HI:FPC_SEL_LO] != FPC_SEL_RSVD)
                  && (st_r.state == FPC_IDLE);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    // a completed instruction after the first key breaks the pair
    if (st_r.armed && instrDone) begin
      if (st_r.armedSeen) begin
        st_nxt.armed = 1'b0;
      end else begin
        st_nxt.armedSeen = 1'b1;
      end
    end

    if (keyWr) begin
      st_nxt.launchKey      = regWdata[FPC_KEY_HI:FPC_KEY_LO];
      st_nxt.latchMapEnable = regWdata[FPC_MAP_BIT];
      st_nxt.spaceSelect    = regWdata[FPC_SEL_HI:FPC_SEL_LO];
      st_nxt.armedSeen      = 1'b0;
      // first key arms; anything else disarms
      st_nxt.armed = (regWdata[FPC_KEY_HI:FPC_KEY_LO] == FPC_KEY_FIRST);
    end

    if (latchWr) begin
      st_nxt.loaded[dataAddr[FPC_BYTE_BITS-1:0]] = 1'b1;
      st_nxt.page = dataAddr[FPC_PAGE_MSB:FPC_BYTE_BITS];
    end

    case (st_r.state)
      FPC_IDLE: begin
        if (launch) begin
          st_nxt.state  = FPC_ERASE;
          st_nxt.target = fpc_sel_t'(regWdata[FPC_SEL_HI:FPC_SEL_LO]);
          st_nxt.timer  = 16'(ERASE_CYC - 1);
        end
      end
      FPC_ERASE: begin
        if (st_r.timer == 16'h0000) begin
          st_nxt.state = FPC_PROG;
          st_nxt.timer = 16'(PROG_CYC - 1);
        end else begin
          st_nxt.timer = st_r.timer - 16'h0001;
        end
      end
      FPC_PROG: begin
        if (st_r.timer == 16'h0000) begin
          st_nxt.state  = FPC_IDLE;
          st_nxt.loaded = '0;
        end else begin
          st_nxt.timer = st_r.timer - 16'h0001;
        end
      end
      default: begin
        st_nxt.state = FPC_IDLE;
      end
    endcase

    // busy bit is not software writable: it reflects the sequencer
    if (regRd) begin
      st_nxt.regRdata = 8'h00;
      if (regAddr == FPC_FLASH_CONTROL_ADDR) begin
        st_nxt.regRdata = {st_r.launchKey, st_r.latchMapEnable, st_r.spaceSelect,
                           (st_r.state != FPC_IDLE)};
      end
    end

    if (codeRd) begin
      case (st_r.spaceSelect)
        FPC_SEL_USER:  st_nxt.codeRdata = userMem[codeAddr[FPC_PAGE_MSB:0] % UBYTES];
        FPC_SEL_EXTRA_ROW:  st_nxt.codeRdata = xrowMem[codeAddr[FPC_BYTE_BITS-1:0]];
        FPC_SEL_SECUR: st_nxt.codeRdata = (codeAddr == FPC_SECUR_ADDR) ? securByte : 8'h00;
        default:       st_nxt.codeRdata = 8'h00;
      endcase
    end

    // programmer reads blocked at level 3 only
    if (pgmRd) begin
      st_nxt.pgmRdata = (lockBits == FPC_LOCK_LVL3) ? 8'h00
                        : userMem[pgmAddr[FPC_PAGE_MSB:0] % UBYTES];
    end
  end

  assign pgmBlocked = (lockBits == FPC_LOCK_LVL2) || (lockBits == FPC_LOCK_LVL3);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r           <= '0;
      st_r.state     <= FPC_IDLE;
      st_r.target    <= FPC_SEL_USER;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // the array keeps content through reset, as flash does
  always_ff @(posedge clk_sys) begin
    if (latchWr) begin
      latchMem[dataAddr[FPC_BYTE_BITS-1:0]] <= dataWdata;
    end
    // commit at the end of programming; erase+write of loaded bytes only
    if (st_r.state == FPC_PROG && st_r.timer == 16'h0000) begin
      for (int i = 0; i < FPC_PAGE_BYTES; i++) begin
        if (st_r.loaded[i]) begin
          case (st_r.target)
            FPC_SEL_USER:  userMem[(int'(st_r.page) * FPC_PAGE_BYTES + i) % UBYTES]
                             <= latchMem[i];
            FPC_SEL_EXTRA_ROW:  xrowMem[i] <= latchMem[i];
            default:       ;
          endcase
        end
      end
      // software reaches only the upper nibble; lock bits stay
      if (st_r.target == FPC_SEL_SECUR && st_r.loaded[0]) begin
        securByte[7:4] <= latchMem[0][7:4];
      end
    end
    // parallel programmer path, the only way to the lock bits
    if (pgmWr && !pgmBlocked) begin
      if (pgmAddr == FPC_SECUR_ADDR) begin
        securByte <= pgmWdata;
      end else begin
        userMem[pgmAddr[FPC_PAGE_MSB:0] % UBYTES] <= pgmWdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign regRdata          = st_r.regRdata;
  assign codeRdata         = st_r.codeRdata;
  assign pgmRdata          = st_r.pgmRdata;
  assign programInProgress = (st_r.state != FPC_IDLE);

endmodule

//--- rtl/fpc_pkg.sv
package fpc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] FPC_FLASH_CONTROL_ADDR = 8'hd1;
  localparam logic [7:0] FPC_FLASH_CONTROL_RST  = 8'h00;

  // ---------------------------------------------------------------
  // field layout of flash_control
  // ---------------------------------------------------------------
  localparam int FPC_KEY_HI   = 7;
  localparam int FPC_KEY_LO   = 4;
  localparam int FPC_MAP_BIT  = 3;
  localparam int FPC_SEL_HI   = 2;
  localparam int FPC_SEL_LO   = 1;
  localparam int FPC_BUSY_BIT = 0;

  localparam logic [3:0] FPC_KEY_FIRST  = 4'h5;
  localparam logic [3:0] FPC_KEY_SECOND = 4'ha;

  // ---------------------------------------------------------------
  // spaces and geometry
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FPC_SEL_USER  = 2'h0,
    FPC_SEL_EXTRA_ROW  = 2'h1,
    FPC_SEL_SECUR = 2'h2,
    FPC_SEL_RSVD  = 2'h3
  } fpc_sel_t;

  localparam int          FPC_PAGE_BYTES = 128;
  localparam int          FPC_BYTE_BITS  = 7;
  localparam int          FPC_PAGE_BITS  = 8;
  localparam int          FPC_PAGE_MSB   = 14;
  localparam logic [15:0] FPC_LATCH_MAX  = 16'h0fff;
  localparam logic [15:0] FPC_EXTRA_ROW_BASE  = 16'hff80;
  localparam logic [15:0] FPC_SECUR_ADDR = 16'h0000;

  // lock levels from the lock bits (1 = programmed)
  localparam logic [1:0] FPC_LOCK_LVL2 = 2'h1;
  localparam logic [1:0] FPC_LOCK_LVL3 = 2'h2;

  // default cell times, cycles of clk_sys
  localparam int FPC_ERASE_CYC = 16;
  localparam int FPC_PROG_CYC  = 16;

  typedef enum { FPC_IDLE, FPC_ERASE, FPC_PROG } fpc_state_t;

  // request from the core toward the array
  typedef struct packed {
    logic       write;
    logic [1:0] space;
    logic [7:0] page;
    logic [6:0] offset;
    logic [7:0] data;
  } fpc_cell_t;

endpackage

//--- tb/fpc_checker.sv
`timescale 1ns/1ps
module fpc_checker
  import fpc_pkg::*;
#(
  parameter int ERASE_CYC = FPC_ERASE_CYC,
  parameter int PROG_CYC  = FPC_PROG_CYC
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic        regWr,
  // core side
  input wire logic        instrDone,
  input wire logic        dataWr,
  input wire logic [15:0] dataAddr,
  input wire logic        dataToLatch,
  input wire logic        codeRd,
  input wire logic [15:0] codeAddr,
  input wire logic [7:0]  codeRdata,
  input wire logic        programInProgress
);
  localparam int BUSY_TOTAL = ERASE_CYC + PROG_CYC;
  logic [15:0] busyCnt;
  logic        mapSh;
  logic [1:0]  selSh;
  wire         ctlWr = regWr && regAddr == FPC_FLASH_CONTROL_ADDR;
  // shadow of map and select, taken from the writes themselves
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busyCnt <= '0;
      mapSh <= 1'b0;
      selSh <= 2'h0;
    end else begin
      busyCnt <= programInProgress ? busyCnt + 16'h1 : 16'h0;
      if (ctlWr) begin
        mapSh <= regWdata[FPC_MAP_BIT];
        selSh <= regWdata[FPC_SEL_HI:FPC_SEL_LO];
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_arm;
    ctlWr && regWdata[7:4] == FPC_KEY_FIRST && regWdata[2:1] != 2'h3 && !programInProgress;
  endsequence
  sequence s_fire;
    ctlWr && regWdata[7:4] == FPC_KEY_SECOND && regWdata[2:1] == selSh;
  endsequence
  property p_launch; s_arm ##1 s_fire |=> programInProgress; endproperty
  property p_abort; s_arm ##1 instrDone [*2] ##1 s_fire |=> !programInProgress; endproperty
  property p_disarm;
    (ctlWr && regWdata[7:4] != FPC_KEY_FIRST && !programInProgress) ##1 s_fire
      |=> !programInProgress;
  endproperty
  property p_rsvd; ctlWr && regWdata[2:1] == 2'h3 && !programInProgress |=> !programInProgress;
  endproperty
  property p_busyLen; $fell(programInProgress) |-> busyCnt == BUSY_TOTAL; endproperty
  property p_busyHold; programInProgress |-> busyCnt < BUSY_TOTAL; endproperty
  property p_latchOff; dataWr && !mapSh && selSh != FPC_SEL_EXTRA_ROW |-> !dataToLatch; endproperty
  property p_latchWin;
    dataWr && mapSh && selSh == FPC_SEL_USER |-> dataToLatch == (dataAddr <= FPC_LATCH_MAX);
  endproperty
  property p_codeZero;
    codeRd && (selSh == FPC_SEL_RSVD || selSh == FPC_SEL_SECUR && codeAddr != FPC_SECUR_ADDR)
      |=> codeRdata == 8'h00;
  endproperty
  a_launch: assert property (p_launch) else $error("no busy after unlock pair");
  a_abort: assert property (p_abort) else $error("launch despite gap");
  a_disarm: assert property (p_disarm) else $error("launch without arm");
  a_rsvd: assert property (p_rsvd) else $error("reserved select launched");
  a_busyLen: assert property (p_busyLen) else $error("busy length wrong");
  a_busyHold: assert property (p_busyHold) else $error("busy overran");
  a_latchOff: assert property (p_latchOff) else $error("latch hit unmapped");
  a_latchWin: assert property (p_latchWin) else $error("latch window wrong");
  a_codeZero: assert property (p_codeZero) else $error("code read not zero");
endmodule

//--- tb/fpc_cpu_model.sv
`timescale 1ns/1ps
module fpc_cpu_model (
  // clock
  input  wire logic        clk_sys,
  // register port
  output logic      [7:0]  regAddr,
  output logic      [7:0]  regWdata,
  output logic             regWr,
  output logic             regRd,
  // core side
  output logic             instrDone,
  output logic             dataWr,
  output logic      [15:0] dataAddr,
  output logic      [7:0]  dataWdata,
  output logic             codeRd,
  output logic      [15:0] codeAddr
);
  initial begin
    {regAddr, regWdata, regWr, regRd, instrDone} = '0;
    {dataWr, dataAddr, dataWdata, codeRd, codeAddr} = '0;
  end
  // one cycle per call: 0 idle, 1 reg write, 2 reg read, 3 data write, 4 code read,
  // 5 other instruction; idle lines scramble so stale values are never trusted
  task automatic op(input int k, input logic [15:0] a, input logic [7:0] d);
    logic [15:0] ad;
    logic [7:0]  dd;
    ad = (k == 0) ? 16'($urandom) : a;
    dd = (k == 0) ? 8'($urandom) : d;
    regWr <= (k == 1);
    regRd <= (k == 2);
    dataWr <= (k == 3);
    codeRd <= (k == 4);
    instrDone <= (k == 5);
    regAddr <= ad[7:0];
    regWdata <= dd;
    dataAddr <= ad;
    dataWdata <= dd;
    codeAddr <= ad;
    @(posedge clk_sys);
  endtask
endmodule

//--- tb/fpc_flash_program_control_test.sv
`timescale 1ns/1ps
module fpc_flash_program_control_test;
  import fpc_pkg::*;
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin badCount++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr, regWdata, regRdata, dataWdata, codeRdata, pg [128];
  logic [15:0] dataAddr, codeAddr, e, pgmAddr;
  logic [7:0] pgmWdata;
  logic regWr, regRd, instrDone, dataWr, codeRd, dataToLatch, programInProgress;
  logic regPend = 1'b0;
  logic codePend = 1'b0;
  logic [7:0] r0, r1, r2;
  logic [15:0] regQ [$], codeQ [$];
  int badCount = 0;
  int totalChecks = 0;
  initial forever #10 clk_sys = ~clk_sys;
  fpc_flash_program_control #(.ERASE_CYC(2), .PROG_CYC(2)) u_fpc_flash_program_control (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .instrDone(instrDone),
    .dataWr(dataWr), .dataAddr(dataAddr), .dataWdata(dataWdata), .dataToLatch(dataToLatch),
    .codeRd(codeRd), .codeAddr(codeAddr), .codeRdata(codeRdata), .pgmWr(1'b0),
    .pgmRd(1'b0), .pgmAddr(pgmAddr), .pgmWdata(pgmWdata), .pgmRdata(), .pgmBlocked(),
    .programInProgress(programInProgress));
  fpc_cpu_model u_fpc_cpu_model (
    .clk_sys(clk_sys), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .instrDone(instrDone), .dataWr(dataWr), .dataAddr(dataAddr),
    .dataWdata(dataWdata), .codeRd(codeRd), .codeAddr(codeAddr));
  // programmer strobes stay low: lock levels are left unprogrammed
  always @(posedge clk_sys) {pgmAddr, pgmWdata} <= 24'($urandom);
  // answers land one cycle after their strobe; queue holds {mask, value}
  always @(posedge clk_sys) begin
    if (regPend) begin e = regQ.pop_front(); `CHK(regRdata & e[15:8], e[7:0]) end
    if (codePend) begin e = codeQ.pop_front(); `CHK(codeRdata & e[15:8], e[7:0]) end
    regPend = regRd;
    codePend = codeRd;
  end
  task automatic op(input int k, input logic [15:0] a, input logic [7:0] d);
    u_fpc_cpu_model.op(k, a, d);
  endtask
  task automatic w(input logic [7:0] d); op(1, 16'(FPC_FLASH_CONTROL_ADDR), d); endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    regQ.push_back(x);
    op(2, 16'(a), 8'h00);
  endtask
  task automatic cr(input logic [15:0] a, input logic [15:0] x);
    codeQ.push_back(x);
    op(4, a, 8'h00);
  endtask
  task automatic go(input logic [7:0] k1, input logic [7:0] k2, input logic b);
    w(k1);
    w(k2);
    op(0, 0, 0);
    `CHK(programInProgress, b)
    while (programInProgress === 1'b1 && totalChecks < 9999) op(0, 0, 0);
  endtask
  task automatic finalReport;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #40000;
    badCount++;
    $display("unexpected at %0t: watchdog expired", $time);
    finalReport();
  end
  initial begin
    void'($urandom(32'hca7f1c4c));
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(8'hd1, 16'hff00);
    rd(8'hd0, 16'hff00);
    w(8'h0e);
    rd(8'hd1, 16'hff0e);
    w(8'h01);
    rd(8'hd1, 16'hff00);
    op(3, 16'h0010, 8'h5a);
    $display("test register done");
    w(8'h08);
    for (int i = 0; i < 128; i++) begin
      pg[i] = 8'($urandom);
      op(3, 16'(5 * 128 + i), pg[i]);
    end
    op(3, 16'h1000, 8'h33);
    w(8'h00);
    w(8'h50);
    w(8'ha0);
    op(0, 0, 0);
    w(8'h00);
    `CHK(programInProgress, 1'b1)
    go(8'h00, 8'h00, 1'b0);
    {r0, r1, r2} = 24'($urandom);
    w(8'h08);
    op(3, 16'h0181, r1);
    op(3, 16'h0280, r0);
    op(3, 16'h02ff, r2);
    w(8'h00);
    go(8'h50, 8'ha0, 1'b1);
    cr(16'h0280, {8'hff, r0});
    cr(16'h0281, {8'hff, r1});
    cr(16'h0282, {8'hff, pg[2]});
    cr(16'h02ff, {8'hff, r2});
    $display("test program done");
    w(8'h08);
    op(3, 16'h0282, ~pg[2]);
    w(8'h50);
    op(5, 0, 0);
    op(5, 0, 0);
    go(8'ha0, 8'h00, 1'b0);
    w(8'h50);
    go(8'h00, 8'ha0, 1'b0);
    go(8'h56, 8'ha6, 1'b0);
    w(8'h00);
    cr(16'h0282, {8'hff, pg[2]});
    $display("test abort done");
    w(8'h0a);
    op(3, 16'hff85, r0);
    go(8'h52, 8'ha2, 1'b1);
    w(8'h02);
    cr(16'hff85, {8'hff, r0});
    w(8'h0c);
    op(3, 16'h0000, r1);
    go(8'h54, 8'ha4, 1'b1);
    w(8'h04);
    cr(16'h0000, {8'hf0, r1 & 8'hf0});
    cr(16'h0001, 16'hff00);
    w(8'h06);
    cr(16'h0000, 16'hff00);
    w(8'h00);
    op(0, 0, 0);
    op(0, 0, 0);
    `CHK(regQ.size() + codeQ.size(), 0)
    $display("test spaces done");
    finalReport();
  end
endmodule
bind fpc_flash_program_control fpc_checker #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC))
  u_fpc_checker (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .instrDone(instrDone), .dataWr(dataWr),
  .dataAddr(dataAddr), .dataToLatch(dataToLatch), .codeRd(codeRd), .codeAddr(codeAddr),
  .codeRdata(codeRdata), .programInProgress(programInProgress));
